// ---- mpc_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH

// ==========================================================
// Register byte offsets
`define MPC_OFS_CTL_ONE      6'h00
`define MPC_OFS_CTL_TWO      6'h04
`define MPC_OFS_OC_PATTERN   6'h08
`define MPC_OFS_FLAGS        6'h0c
`define MPC_OFS_HALL_CMP     6'h10
`define MPC_OFS_STATUS       6'h14
`define MPC_OFS_HALL_CAPT    6'h18

// ==========================================================
// guard_control_one fields
`define MPC_C1_HW_FAST_OC    0
`define MPC_C1_SW_FAST_OC    1
`define MPC_C1_LIM_HWEN      2
`define MPC_C1_OC_HWEN       3
`define MPC_C1_CMP_HWEN      4
`define MPC_C1_OVF_HWEN      5
`define MPC_C1_SW_EN         6
`define MPC_C1_SW_DATA       7

// ==========================================================
// guard_control_two fields (1 = Pause, 0 = Fault; software guard does nothing at 0; bit 3 selects limit restart)
`define MPC_C2_OVF_MODE      0
`define MPC_C2_CMP_MODE      1
`define MPC_C2_OC_MODE       2
`define MPC_C2_LIM_RESTART   3
`define MPC_C2_SW_MODE       4

// ==========================================================
// motor_control_flags fields
`define MPC_FL_STOP_STYLE    0

// ==========================================================
// Reset values
`define MPC_RST_CTL_ONE      8'h00
`define MPC_RST_CTL_TWO      5'h00
`define MPC_RST_OC_PATTERN   6'h00
`define MPC_RST_HALL_CMP     16'hffff

// ==========================================================
// Drive patterns, bit order AT AB BT BB CT CB
`define MPC_BRAKE_PATTERN    6'h15
`define MPC_FREE_PATTERN     6'h00

// ==========================================================
// Timing
`define MPC_FILTER_CYCLES    2
`define MPC_HALL_PRESCALE    8'h3f

`endif

// ---- mpc_pkg.sv ----
// Types shared by the motor protection control design
package mpc_pkg;

  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } mpc_bus_e;

  typedef logic [5:0]  mpc_drive_t;
  typedef logic [15:0] mpc_count_t;

endpackage : mpc_pkg

// ---- mpc_hall_timer.sv ----
// Hall period capture timer with compare and overflow events
`include "mpc_regs.svh"

module mpc_hall_timer
  import mpc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Hall pins, asynchronous
  input  wire logic [2:0] hall_pins,
  // Compare value from software
  input  wire mpc_count_t compare_value,
  // Events and captured period
  output logic            compare_event,
  output logic            overflow_event,
  output mpc_count_t      captured_period
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] hall_meta;
  logic [2:0] hall_sync;
  logic [2:0] hall_prev;
  logic [7:0] prescale;
  logic       tick;
  mpc_count_t hall_period_timer;
  logic       hall_edge;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hall_meta <= 3'h0;
      hall_sync <= 3'h0;
      hall_prev <= 3'h0;
    end else begin
      hall_meta <= hall_pins;
      hall_sync <= hall_meta;
      hall_prev <= hall_sync;
    end
  end

  assign hall_edge = |(hall_sync ^ hall_prev);

  // ==========================================================
  // Prescaler, keeps a 16-bit period useful at slow speeds
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescale <= 8'h00;
    end else if (prescale == `MPC_HALL_PRESCALE) begin
      prescale <= 8'h00;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  assign tick = (prescale == `MPC_HALL_PRESCALE);

  // ==========================================================
  // Period counter, capture and events
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hall_period_timer <= 16'h0000;
      captured_period   <= 16'h0000;
      compare_event     <= 1'b0;
      overflow_event    <= 1'b0;
    end else begin
      compare_event  <= 1'b0;
      overflow_event <= 1'b0;
      if (hall_edge) begin
        captured_period   <= hall_period_timer;
        hall_period_timer <= 16'h0000;
      end else if (tick) begin
        hall_period_timer <= hall_period_timer + 16'h0001;
        // Period too long: rotor slow or stalled
        compare_event     <= (hall_period_timer + 16'h0001 == compare_value);
        overflow_event    <= (hall_period_timer == 16'hffff);
      end
    end
  end

endmodule : mpc_hall_timer

// ---- mpc_guard.sv ----
// Motor protection control: guard sources, fast over-current, drive mux
`include "mpc_regs.svh"

module mpc_guard
  import mpc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Avalon-MM slave
  input  wire logic [5:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  output logic [31:0]      READDATA,
  output logic             WAITREQUEST,
  // Analog front end and limit circuit
  input  wire logic        CMP_OUT,
  input  wire logic        CURRENT_LIMIT_EVENT,
  input  wire logic        ADC_SEL_AMPLIFIER,
  input  wire logic        PWM_PERIOD_START,
  // Hall sensor pins
  input  wire logic        HALL_INPUT_ONE,
  input  wire logic        HALL_INPUT_TWO,
  input  wire logic        HALL_INPUT_THREE,
  // Gate drive path
  input  wire mpc_drive_t  DRIVE_IN,
  output mpc_drive_t       DRIVE_OUT,
  // Guard state
  output logic             MOTOR_GUARD,
  output logic             FAST_OVERCURRENT_GUARD
);

  // ==========================================================
  // Registers
  logic [7:0]  guard_control_one;
  logic [4:0]  guard_control_two;
  mpc_drive_t  overcurrent_output_pattern;
  logic        stop_style_select;
  mpc_count_t  hall_timer_compare;
  mpc_bus_e    bus_state;
  logic        access_done;
  logic        wr_en;
  logic [31:0] next_readdata;

  function automatic logic hit(input logic [5:0] addr,
                               input logic [5:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ==========================================================
  // Bus slave: one wait state, answer on second edge
  assign access_done = (bus_state == BUS_DONE);
  assign WAITREQUEST = (READ | WRITE) & ~access_done;
  assign wr_en       = WRITE & access_done;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_IDLE: bus_state <= (READ | WRITE) ? BUS_DONE : BUS_IDLE;
        BUS_DONE: bus_state <= BUS_IDLE;
        default:  bus_state <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      guard_control_one          <= `MPC_RST_CTL_ONE;
      guard_control_two          <= `MPC_RST_CTL_TWO;
      overcurrent_output_pattern <= `MPC_RST_OC_PATTERN;
      stop_style_select          <= 1'b0;
      hall_timer_compare         <= `MPC_RST_HALL_CMP;
    end else if (wr_en) begin
      if (hit(ADDRESS, `MPC_OFS_CTL_ONE))
        guard_control_one <= WRITEDATA[7:0];
      if (hit(ADDRESS, `MPC_OFS_CTL_TWO))
        guard_control_two <= WRITEDATA[4:0];
      if (hit(ADDRESS, `MPC_OFS_OC_PATTERN))
        overcurrent_output_pattern <= WRITEDATA[5:0];
      if (hit(ADDRESS, `MPC_OFS_FLAGS))
        stop_style_select <= WRITEDATA[`MPC_FL_STOP_STYLE];
      if (hit(ADDRESS, `MPC_OFS_HALL_CMP))
        hall_timer_compare <= WRITEDATA[15:0];
    end
  end

  // ==========================================================
  // Field aliases
  logic hw_fast_oc_enable, sw_fast_oc_enable;
  logic current_limit_hw_enable, overcurrent_hw_enable;
  logic stall_compare_hw_enable, stall_overflow_hw_enable;
  logic sw_guard_enable, sw_guard_data;
  logic stall_overflow_mode_select, stall_compare_mode_select;
  logic overcurrent_mode_select, current_limit_restart_select;
  logic sw_guard_mode_select;

  assign hw_fast_oc_enable        = guard_control_one[`MPC_C1_HW_FAST_OC];
  assign sw_fast_oc_enable        = guard_control_one[`MPC_C1_SW_FAST_OC];
  assign current_limit_hw_enable  = guard_control_one[`MPC_C1_LIM_HWEN];
  assign overcurrent_hw_enable    = guard_control_one[`MPC_C1_OC_HWEN];
  assign stall_compare_hw_enable  = guard_control_one[`MPC_C1_CMP_HWEN];
  assign stall_overflow_hw_enable = guard_control_one[`MPC_C1_OVF_HWEN];
  assign sw_guard_enable          = guard_control_one[`MPC_C1_SW_EN];
  assign sw_guard_data            = guard_control_one[`MPC_C1_SW_DATA];
  assign stall_overflow_mode_select = guard_control_two[`MPC_C2_OVF_MODE];
  assign stall_compare_mode_select  = guard_control_two[`MPC_C2_CMP_MODE];
  assign overcurrent_mode_select    = guard_control_two[`MPC_C2_OC_MODE];
  assign current_limit_restart_select =
    guard_control_two[`MPC_C2_LIM_RESTART];
  assign sw_guard_mode_select       = guard_control_two[`MPC_C2_SW_MODE];

  // ==========================================================
  // Comparator synchroniser and two-clock glitch filter
  logic cmp_meta, cmp_sync, cmp_hist, oc_level, oc_level_q;
  logic overcurrent_compare_pulse;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      cmp_meta   <= 1'b0;
      cmp_sync   <= 1'b0;
      cmp_hist   <= 1'b0;
      oc_level_q <= 1'b0;
    end else begin
      cmp_meta   <= CMP_OUT;
      cmp_sync   <= cmp_meta;
      cmp_hist   <= cmp_sync;
      oc_level_q <= oc_level;
    end
  end

  // High for two clocks before it counts
  assign oc_level = cmp_sync & cmp_hist;
  assign overcurrent_compare_pulse = oc_level & ~oc_level_q;

  // ==========================================================
  // Hall period timer
  logic       hall_timer_compare_event, hall_timer_overflow_event;
  mpc_count_t hall_captured;

  mpc_hall_timer u_hall_timer (
    .clk             (CLK_SYS),
    .nrst            (NRST),
    .hall_pins       ({HALL_INPUT_THREE, HALL_INPUT_TWO, HALL_INPUT_ONE}),
    .compare_value   (hall_timer_compare),
    .compare_event   (hall_timer_compare_event),
    .overflow_event  (hall_timer_overflow_event),
    .captured_period (hall_captured)
  );

  // ==========================================================
  // Software release detection
  logic sw_en_q, sw_data_q, sw_en_dropped, release_pulse;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sw_en_q       <= 1'b0;
      sw_data_q     <= 1'b0;
      sw_en_dropped <= 1'b0;
    end else begin
      sw_en_q   <= sw_guard_enable;
      sw_data_q <= sw_guard_data;
      // Remember a 1 to 0 step, armed for the next rise
      if (sw_en_q & ~sw_guard_enable)
        sw_en_dropped <= 1'b1;
      else if (sw_guard_enable)
        sw_en_dropped <= 1'b0;
    end
  end

  // Enable 1-0-1, or data falling while enabled
  assign release_pulse = (sw_guard_enable & sw_en_dropped) |
                         (sw_guard_enable & sw_data_q & ~sw_guard_data);

  // ==========================================================
  // Trigger sources
  logic oc_trig, lim_cond, cmp_trig, ovf_trig;
  logic oc_latch, cmp_latch, ovf_latch, sw_latch;
  logic oc_src, cmp_src, ovf_src, sw_src;
  logic lim_hold;

  assign oc_trig  = overcurrent_hw_enable & overcurrent_compare_pulse;
  // Amplifier channel gates the limit
  assign lim_cond = current_limit_hw_enable & ADC_SEL_AMPLIFIER &
                    CURRENT_LIMIT_EVENT;
  assign cmp_trig = stall_compare_hw_enable & hall_timer_compare_event;
  assign ovf_trig = stall_overflow_hw_enable & hall_timer_overflow_event;

  // Pause latches, set wins over release
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      oc_latch  <= 1'b0;
      cmp_latch <= 1'b0;
      ovf_latch <= 1'b0;
      sw_latch  <= 1'b0;
    end else begin
      oc_latch  <= (oc_trig & overcurrent_mode_select) |
                   (oc_latch & ~release_pulse);
      cmp_latch <= (cmp_trig & stall_compare_mode_select) |
                   (cmp_latch & ~release_pulse);
      ovf_latch <= (ovf_trig & stall_overflow_mode_select) |
                   (ovf_latch & ~release_pulse);
      sw_latch  <= (sw_guard_enable & sw_guard_data &
                    sw_guard_mode_select) |
                   (sw_latch & ~release_pulse);
    end
  end

  // Trigger shows at once; Fault follows the live condition
  assign oc_src  = oc_latch | oc_trig |
                   (overcurrent_hw_enable & oc_level &
                    ~overcurrent_mode_select);
  // Pause latch only takes over from the next edge
  assign cmp_src = cmp_latch | cmp_trig;
  assign ovf_src = ovf_latch | ovf_trig;
  assign sw_src  = sw_latch |
                   (sw_guard_enable & sw_guard_data & sw_guard_mode_select);

  // Limit restart: armed while limiting, so no gap opens at release
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lim_hold <= 1'b0;
    end else begin
      if (lim_cond & current_limit_restart_select)
        lim_hold <= 1'b1;
      else if (PWM_PERIOD_START | ~current_limit_restart_select)
        lim_hold <= 1'b0;
    end
  end

  assign MOTOR_GUARD = oc_src | lim_cond | lim_hold | cmp_src |
                       ovf_src | sw_src;

  // ==========================================================
  // Fast over-current guard
  logic fast_hw, hw_fast_q, hw_fast_rise;

  assign hw_fast_rise = hw_fast_oc_enable & ~hw_fast_q;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      hw_fast_q <= 1'b0;
      fast_hw   <= 1'b0;
    end else begin
      hw_fast_q <= hw_fast_oc_enable;
      // Pulse latched; only the enable rise clears it
      fast_hw <= (hw_fast_oc_enable & overcurrent_compare_pulse) |
                 (fast_hw & ~hw_fast_rise);
    end
  end

  // Software bit is a direct level
  assign FAST_OVERCURRENT_GUARD = fast_hw | sw_fast_oc_enable;

  // ==========================================================
  // Drive mux, per phase, no pipeline stage
  mpc_drive_t stop_pattern;
  assign stop_pattern = stop_style_select ? `MPC_FREE_PATTERN
                                          : `MPC_BRAKE_PATTERN;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      assign DRIVE_OUT[2*ph+1 -: 2] =
        FAST_OVERCURRENT_GUARD ? overcurrent_output_pattern[2*ph+1 -: 2] :
        MOTOR_GUARD            ? stop_pattern[2*ph+1 -: 2] :
                                 DRIVE_IN[2*ph+1 -: 2];
    end
  endgenerate

  // ==========================================================
  // Read data
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hit(ADDRESS, `MPC_OFS_CTL_ONE))
      next_readdata[7:0] = guard_control_one;
    if (hit(ADDRESS, `MPC_OFS_CTL_TWO))
      next_readdata[4:0] = guard_control_two;
    if (hit(ADDRESS, `MPC_OFS_OC_PATTERN))
      next_readdata[5:0] = overcurrent_output_pattern;
    if (hit(ADDRESS, `MPC_OFS_FLAGS))
      next_readdata[0] = stop_style_select;
    if (hit(ADDRESS, `MPC_OFS_HALL_CMP))
      next_readdata[15:0] = hall_timer_compare;
    if (hit(ADDRESS, `MPC_OFS_STATUS))
      next_readdata[7:0] = {lim_hold, sw_src, ovf_src, cmp_src, oc_src,
                            fast_hw, FAST_OVERCURRENT_GUARD, MOTOR_GUARD};
    if (hit(ADDRESS, `MPC_OFS_HALL_CAPT))
      next_readdata[15:0] = hall_captured;
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      READDATA <= 32'h0000_0000;
    end else if (READ & ~access_done) begin
      READDATA <= next_readdata;
    end
  end

  // ==========================================================
  // Assertions
  property p_stop_style;
    @(posedge CLK_SYS) disable iff (!NRST)
      MOTOR_GUARD && !FAST_OVERCURRENT_GUARD |->
        DRIVE_OUT == (stop_style_select ? 6'h00 : 6'h15);
  endproperty
  a_stop_style: assert property (p_stop_style)
    else $error("Guard does not force the stop pattern");

  property p_fault_release;
    @(posedge CLK_SYS) disable iff (!NRST)
      $fell(oc_level) && !overcurrent_mode_select && !oc_latch
        |-> !oc_src;
  endproperty
  a_fault_release: assert property (p_fault_release)
    else $error("Fault source not released with its trigger");

  property p_pause_hold;
    @(posedge CLK_SYS) disable iff (!NRST)
      cmp_latch && !release_pulse |=> cmp_latch && MOTOR_GUARD;
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("Pause latch dropped without release");

  property p_fast_pattern;
    @(posedge CLK_SYS) disable iff (!NRST)
      FAST_OVERCURRENT_GUARD |-> DRIVE_OUT == overcurrent_output_pattern;
  endproperty
  a_fast_pattern: assert property (p_fast_pattern)
    else $error("Fast guard pattern not driven");

  property p_fast_sticky;
    @(posedge CLK_SYS) disable iff (!NRST)
      fast_hw && !($rose(hw_fast_oc_enable)) ##1 !hw_fast_rise
        |-> fast_hw;
  endproperty
  a_fast_sticky: assert property (p_fast_sticky)
    else $error("Fast guard cleared without enable rise");

  property p_filter;
    @(posedge CLK_SYS) disable iff (!NRST)
      overcurrent_compare_pulse |-> cmp_sync && $past(cmp_sync)
                                    && !$past(cmp_sync, 2);
  endproperty
  a_filter: assert property (p_filter)
    else $error("Compare pulse without two filtered clocks");

  property p_limit_gate;
    @(posedge CLK_SYS) disable iff (!NRST)
      !current_limit_hw_enable || !ADC_SEL_AMPLIFIER |-> !lim_cond;
  endproperty
  a_limit_gate: assert property (p_limit_gate)
    else $error("Limit acted while disabled");

  property p_restart_wait;
    @(posedge CLK_SYS) disable iff (!NRST)
      $fell(lim_cond) && current_limit_restart_select &&
        $past(current_limit_restart_select) |->
        MOTOR_GUARD ##1 (MOTOR_GUARD || $past(PWM_PERIOD_START));
  endproperty
  a_restart_wait: assert property (p_restart_wait)
    else $error("PWM resumed before next period");

  property p_hw_latch;
    @(posedge CLK_SYS) disable iff (!NRST)
      hw_fast_oc_enable && overcurrent_compare_pulse |=>
        FAST_OVERCURRENT_GUARD [*2];
  endproperty
  a_hw_latch: assert property (p_hw_latch)
    else $error("Over-current pulse not latched");

  property p_sw_fast;
    @(posedge CLK_SYS) disable iff (!NRST)
      sw_fast_oc_enable |-> FAST_OVERCURRENT_GUARD;
  endproperty
  a_sw_fast: assert property (p_sw_fast)
    else $error("Software fast guard not asserted");

  property p_stall_cmp;
    @(posedge CLK_SYS) disable iff (!NRST)
      hall_timer_compare_event && stall_compare_hw_enable |-> MOTOR_GUARD;
  endproperty
  a_stall_cmp: assert property (p_stall_cmp)
    else $error("Stall compare did not guard");

  c_fast_hw:  cover property (@(posedge CLK_SYS) disable iff (!NRST)
                              $rose(fast_hw));
  c_release:  cover property (@(posedge CLK_SYS) disable iff (!NRST)
                              release_pulse && cmp_latch);
  c_lim_hold: cover property (@(posedge CLK_SYS) disable iff (!NRST)
                              $rose(lim_hold));

endmodule : mpc_guard

// ---- mpc_gate_model.sv ----
// Gate drive transistor pair model watching the driver outputs
module mpc_gate_model
  import mpc_pkg::*;
(
  // Gate inputs, bit order AT AB BT BB CT CB
  input  wire mpc_drive_t gate,
  // Pair state
  output logic            shoot_through,
  output logic            low_all_on
);
  // Both sides of one pair on would short the supply
  assign shoot_through = |(gate & (gate << 1) & 6'h2a);
  assign low_all_on    = (gate & 6'h15) == 6'h15;
endmodule : mpc_gate_model

// ---- testbench.sv ----
// Self-checking bench for the motor protection control block
`include "mpc_regs.svh"
module testbench
  import mpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, nrst = 0, rd_en = 0, wr_en = 0, cmp = 0;
  logic        lim = 0, adc = 0, pwm = 0, wait_req, guard, fast;
  logic        shoot, low_on;
  logic [2:0]  hall = 3'h0;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  mpc_drive_t  din = 6'h2a, dout;
  mpc_drive_t  pat = 6'h00;
  int          mismatches = 0, check_count = 0, cyc = 0, style = 0;

  mpc_guard mpc_guard_i (.CLK_SYS(clk), .NRST(nrst), .ADDRESS(addr),
    .READ(rd_en), .WRITE(wr_en), .WRITEDATA(wdata), .READDATA(rdata),
    .WAITREQUEST(wait_req), .CMP_OUT(cmp), .CURRENT_LIMIT_EVENT(lim),
    .ADC_SEL_AMPLIFIER(adc), .PWM_PERIOD_START(pwm),
    .HALL_INPUT_ONE(hall[0]), .HALL_INPUT_TWO(hall[1]),
    .HALL_INPUT_THREE(hall[2]), .DRIVE_IN(din), .DRIVE_OUT(dout),
    .MOTOR_GUARD(guard), .FAST_OVERCURRENT_GUARD(fast));
  mpc_gate_model mpc_gate_model_i (.gate(dout), .shoot_through(shoot),
    .low_all_on(low_on));

  always #12.5 clk = ~clk;
  // Hang guard, well above the longest stall wait
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ======
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp_val

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input bit w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge clk); while (wait_req !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  // Model: fast pattern wins, then stop pattern, else live drive
  // One edge first, so latched sources and releases have settled
  task automatic chk(input bit g, input bit f);
    @(posedge clk);
    @(negedge clk);
    cmp_val(guard, g);
    cmp_val(fast, f);
    cmp_val(dout, f ? pat : g ? (style ? `MPC_FREE_PATTERN
      : `MPC_BRAKE_PATTERN) : din);
    if (g && !f && style == 0) cmp_val(low_on, 1'b1);
    if (g && !f) cmp_val(shoot, 1'b0);
  endtask : chk

  // ======
  // Scenarios
  initial begin
    void'($urandom(6603));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    chk(0, 0);
    bus(0, `MPC_OFS_HALL_CMP, 0);
    cmp_val(rd, 32'hffff);
    bus(0, 6'h3c, 0);
    cmp_val(rd, 32'h0);
    bus(1, `MPC_OFS_CTL_ONE, 32'h08);
    @(posedge clk) cmp <= 1'b1;
    @(posedge clk) cmp <= 1'b0;
    repeat (4) chk(0, 0);
    for (int s = 0; s < 2; s++) begin
      style = s;
      bus(1, `MPC_OFS_FLAGS, s);
      @(posedge clk) begin cmp <= 1'b1; din <= 6'($urandom); end
      repeat (4) @(posedge clk);
      chk(1, 0);
      @(posedge clk) cmp <= 1'b0;
      repeat (4) @(posedge clk);
      chk(0, 0);
    end
    pat = 6'($urandom);
    bus(1, `MPC_OFS_OC_PATTERN, pat);
    bus(1, `MPC_OFS_CTL_ONE, 32'h09);
    @(posedge clk) cmp <= 1'b1;
    repeat (3) @(posedge clk);
    cmp <= 1'b0;
    repeat (6) @(posedge clk);
    chk(0, 1);
    bus(1, `MPC_OFS_CTL_ONE, 32'h08);
    chk(0, 1);
    bus(1, `MPC_OFS_CTL_ONE, 32'h09);
    chk(0, 0);
    bus(1, `MPC_OFS_CTL_ONE, 32'h02);
    chk(0, 1);
    bus(1, `MPC_OFS_CTL_ONE, 32'h00);
    chk(0, 0);
    bus(1, `MPC_OFS_CTL_ONE, 32'h04);
    for (int r = 0; r < 2; r++) begin
      bus(1, `MPC_OFS_CTL_TWO, r << 3);
      @(posedge clk) lim <= 1'b1;
      chk(0, 0);
      @(posedge clk) adc <= 1'b1;
      chk(1, 0);
      @(posedge clk) lim <= 1'b0;
      chk(r, 0);
      @(posedge clk) pwm <= 1'b1;
      @(posedge clk) begin pwm <= 1'b0; adc <= 1'b0; end
      chk(0, 0);
    end
    bus(1, `MPC_OFS_CTL_TWO, 32'h13);
    bus(1, `MPC_OFS_CTL_ONE, 32'hc0);
    chk(1, 0);
    bus(1, `MPC_OFS_CTL_ONE, 32'h40);
    chk(0, 0);
    // Hall edge restarts the period count, else no match for ages
    @(posedge clk) hall <= 3'h1;
    bus(1, `MPC_OFS_HALL_CMP, 32'h2);
    bus(1, `MPC_OFS_CTL_ONE, 32'h50);
    while (guard !== 1'b1) @(posedge clk);
    repeat (3) chk(1, 0);
    bus(1, `MPC_OFS_CTL_ONE, 32'h10);
    bus(1, `MPC_OFS_CTL_ONE, 32'h50);
    chk(0, 0);
    give_verdict();
  end
endmodule : testbench
